// [rtl/irq_power_pkg.sv]
// Constants shared by the interrupt and power-mode logic.
// Assumes one 10 MHz clock that doubles as the oscillator clock.
`default_nettype none

package irq_power_pkg;

    // ------------------------------------------------------------
    // Interrupt sources and vectors
    // ------------------------------------------------------------
    localparam int         NUM_SRC    = 5;
    localparam int         NUM_HW_SRC = 4;
    localparam int         SRC_W      = 3;
    localparam logic [2:0] SRC_EXT0   = 3'h0;
    localparam logic [2:0] SRC_TMR0   = 3'h1;
    localparam logic [2:0] SRC_EXT1   = 3'h2;
    localparam logic [2:0] SRC_TMR1   = 3'h3;
    localparam logic [2:0] SRC_SERIAL = 3'h4;
    localparam int         VEC_W      = 16;
    localparam logic [15:0] VEC_EXT0   = 16'h0003;
    localparam logic [15:0] VEC_TMR0   = 16'h000b;
    localparam logic [15:0] VEC_EXT1   = 16'h0013;
    localparam logic [15:0] VEC_TMR1   = 16'h001b;
    localparam logic [15:0] VEC_SERIAL = 16'h0023;

    // ------------------------------------------------------------
    // Power control register
    // ------------------------------------------------------------
    localparam int         POWER_CONTROL_REGISTER_W       = 8;
    localparam int         POWER_CONTROL_REGISTER_IDLE_BIT = 0;
    localparam int         POWER_CONTROL_REGISTER_PD_BIT  = 1;
    localparam logic [7:0] POWER_CONTROL_REGISTER_RESET   = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 10;
    localparam int OSC_PER_MC    = 12;
    localparam int LAT_XTAL_MHZ  = 12;
    localparam int LAT_MIN_US    = 3;
    localparam int LAT_MAX_US    = 7;
    localparam int LAT_MIN_MC    = (LAT_MIN_US * LAT_XTAL_MHZ + OSC_PER_MC - 1) / OSC_PER_MC;
    localparam int LAT_MAX_MC    = (LAT_MAX_US * LAT_XTAL_MHZ) / OSC_PER_MC;
    localparam int MC_CNT_W      = 4;

    typedef enum logic [1:0] {
        PWR_RUN  = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_DOWN = 2'b10
    } pwr_state_e;

endpackage

`default_nettype wire

// [rtl/pin_sync2.sv]
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes the pins are quasi-static compared with i_clk.
`default_nettype none

module pin_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Pins and synchronised copy
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_reg;

    // Pins idle high, so both stages reset high to avoid a false request.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_reg <= '1;
            o_q      <= '1;
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// [rtl/irq_flag.sv]
// One hardware-cleared request flag, edge or level triggered.
// Assumes i_active is already in the i_clk domain.
`default_nettype none

module irq_flag (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Control
    input  wire logic i_level_mode,
    input  wire logic i_active,
    input  wire logic i_clear,
    // Flag
    output logic      o_flag
);

    logic prev_reg;
    logic set;

    assign set = i_level_mode ? i_active : (i_active & ~prev_reg);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= i_active;
        end
    end

    // A new edge in the cycle of the clear wins, so no event is lost.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_flag <= 1'b0;
        end else if (set) begin
            o_flag <= 1'b1;
        end else if (i_clear || i_level_mode) begin
            o_flag <= 1'b0;
        end
    end

    a_flag_set_wins:
    assert property (@(posedge i_clk) disable iff (i_srst) set |=> o_flag)
        else $error("flag lost an event");

    a_flag_hw_clear:
    assert property (@(posedge i_clk) disable iff (i_srst)
        (i_clear && !set && !i_level_mode) |=> !o_flag)
        else $error("flag not cleared on vectoring");

endmodule

`default_nettype wire

// [rtl/irq_power_ctrl.sv]
// Interrupt controller and idle / power-down control of the MCU.
// Assumes a CPU core that takes vectors on i_irq_ack and signals returns
// on i_reti, and on-chip peripherals on i_clk that pulse or hold flags.
`default_nettype none

module irq_power_ctrl
    import irq_power_pkg::*;
(
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_srst,
    // Pins, asynchronous
    input  wire logic                        i_ext_irq_0_n,
    input  wire logic                        i_external_irq_1_n,
    input  wire logic                        i_ext_access_n,
    // Peripheral requests
    input  wire logic                        i_timer0_ovf,
    input  wire logic                        i_timer1_ovf,
    input  wire logic                        i_serial_flag,
    input  wire logic                        i_nvm_irq_flag,
    input  wire logic                        i_nvm_irq_enable,
    input  wire logic                        i_erase_write_busy_flag,
    // Interrupt configuration
    input  wire logic                        i_global_enable,
    input  wire logic [irq_power_pkg::NUM_SRC-1:0] i_source_enable,
    input  wire logic [irq_power_pkg::NUM_SRC-1:0] i_source_high_pri,
    input  wire logic [1:0]                  i_ext_level_mode,
    // Power control register access
    input  wire logic                        i_power_control_register_wr,
    input  wire logic [irq_power_pkg::POWER_CONTROL_REGISTER_W-1:0] i_power_control_register_wdata,
    output logic      [irq_power_pkg::POWER_CONTROL_REGISTER_W-1:0] o_power_control_register,
    // CPU interrupt handshake
    input  wire logic                        i_irq_ack,
    input  wire logic                        i_reti,
    output logic                             o_irq_req,
    output logic      [irq_power_pkg::VEC_W-1:0] o_irq_vector,
    output logic                             o_irq_high,
    output logic      [irq_power_pkg::NUM_SRC-1:0] o_irq_flags,
    // Power and pin control
    output logic                             o_cpu_halt,
    output logic                             o_osc_stop,
    output logic                             o_nvm_abort,
    output logic                             o_pin_override,
    output logic                             o_ale_level,
    output logic                             o_program_store_strobe_level,
    output logic                             o_port0_float,
    output logic                             o_port2_address
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [MC_CNT_W-1:0]   mc_cnt_reg;
    logic                  mc_tick;
    logic [2:0]            pin_sync;
    logic                  strap_done_reg;
    logic                  ext_mem_reg;
    logic [NUM_HW_SRC-1:0] hw_act;
    logic [NUM_HW_SRC-1:0] hw_lvl;
    logic [NUM_HW_SRC-1:0] hw_clr;
    logic [NUM_HW_SRC-1:0] hw_flag;
    logic                  nvm_req;
    logic [NUM_SRC-1:0]    flags;
    logic [NUM_SRC-1:0]    eligible;
    logic [NUM_SRC-1:0]    seen_reg;
    logic [NUM_SRC-1:0]    cand;
    logic                  in_hi_reg;
    logic                  in_lo_reg;
    logic                  sel_ok;
    logic                  sel_hi;
    logic [SRC_W-1:0]      sel_src;
    logic [SRC_W-1:0]      req_src_reg;
    logic                  ack_take;
    logic                  wake;
    logic                  power_control_register_wr_ok;
    pwr_state_e            pwr_reg;
    pwr_state_e            pwr_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [SRC_W-1:0] first_src(input logic [NUM_SRC-1:0] m);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (m[k]) begin
                r = k[SRC_W-1:0];
            end
        end
        return r;
    endfunction

    function automatic logic [VEC_W-1:0] vec_of(input logic [SRC_W-1:0] s);
        logic [VEC_W-1:0] v;
        case (s)
            SRC_EXT0: v = VEC_EXT0;
            SRC_TMR0: v = VEC_TMR0;
            SRC_EXT1: v = VEC_EXT1;
            SRC_TMR1: v = VEC_TMR1;
            default:  v = VEC_SERIAL;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Machine-cycle divider
    // ------------------------------------------------------------
    assign mc_tick = (mc_cnt_reg == MC_CNT_W'(OSC_PER_MC - 1));

    always_ff @(posedge i_clk) begin
        if (i_srst || mc_tick) begin
            mc_cnt_reg <= '0;
        end else begin
            mc_cnt_reg <= mc_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pins and program-memory strap
    // ------------------------------------------------------------
    pin_sync2 #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_d    ({i_external_irq_1_n, i_ext_irq_0_n}),
        .o_q    (pin_sync[1:0])
    );

    // The strap copy stays out of reset so that it already holds the settled
    // pin at release; a reset copy would always read internal memory.
    pin_sync2 #(
        .WIDTH (1)
    ) u_strap_sync (
        .i_clk  (i_clk),
        .i_srst (1'b0),
        .i_d    (i_ext_access_n),
        .o_q    (pin_sync[2])
    );

    // The memory strap is caught once after reset release, never live.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            strap_done_reg <= 1'b0;
            ext_mem_reg    <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            ext_mem_reg    <= ~pin_sync[2];
        end
    end

    // ------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------
    assign hw_act = {i_timer1_ovf, ~pin_sync[1], i_timer0_ovf, ~pin_sync[0]};
    assign hw_lvl = {1'b0, i_ext_level_mode[1], 1'b0, i_ext_level_mode[0]};

    for (genvar g = 0; g < NUM_HW_SRC; g++) begin : g_flag
        assign hw_clr[g] = ack_take && (req_src_reg == SRC_W'(g));
        irq_flag u_flag (
            .i_clk        (i_clk),
            .i_srst       (i_srst),
            .i_level_mode (hw_lvl[g]),
            .i_active     (hw_act[g]),
            .i_clear      (hw_clr[g]),
            .o_flag       (hw_flag[g])
        );
    end

    // Serial and memory flags are owned and cleared by their peripherals.
    assign nvm_req  = i_nvm_irq_flag && i_nvm_irq_enable;
    assign flags    = {i_serial_flag | nvm_req, hw_flag};
    assign eligible = flags & i_source_enable & {NUM_SRC{i_global_enable}};
    assign o_irq_flags = flags;

    // ------------------------------------------------------------
    // Priority selection and polling
    // ------------------------------------------------------------
    assign cand = seen_reg & eligible;

    always_comb begin
        sel_ok  = 1'b0;
        sel_hi  = 1'b0;
        sel_src = '0;
        if (|(cand & i_source_high_pri) && !in_hi_reg) begin
            sel_ok  = 1'b1;
            sel_hi  = 1'b1;
            sel_src = first_src(cand & i_source_high_pri);
        end else if (|(cand & ~i_source_high_pri) && !in_hi_reg && !in_lo_reg) begin
            sel_ok  = 1'b1;
            sel_src = first_src(cand & ~i_source_high_pri);
        end
    end

    assign ack_take = i_irq_ack && o_irq_req;

    // Flags are latched at one machine-cycle boundary and polled at the next,
    // which keeps the request inside the allowed response window.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            seen_reg <= '0;
        end else if (mc_tick) begin
            seen_reg <= eligible;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_irq_req    <= 1'b0;
            o_irq_high   <= 1'b0;
            o_irq_vector <= '0;
            req_src_reg  <= '0;
        end else if (ack_take || !i_global_enable || pwr_reg == PWR_DOWN) begin
            o_irq_req <= 1'b0;
        end else if (mc_tick && sel_ok && !o_irq_req) begin
            o_irq_req    <= 1'b1;
            o_irq_high   <= sel_hi;
            req_src_reg  <= sel_src;
            o_irq_vector <= vec_of(sel_src);
        end
    end

    // In-service levels give two nesting levels; a return pops the higher.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            in_hi_reg <= 1'b0;
            in_lo_reg <= 1'b0;
        end else if (ack_take) begin
            in_hi_reg <= in_hi_reg | o_irq_high;
            in_lo_reg <= in_lo_reg | ~o_irq_high;
        end else if (i_reti) begin
            if (in_hi_reg) begin
                in_hi_reg <= 1'b0;
            end else begin
                in_lo_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    assign wake       = |eligible;
    assign power_control_register_wr_ok = i_power_control_register_wr && (pwr_reg == PWR_RUN);

    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            PWR_RUN: begin
                if (power_control_register_wr_ok && i_power_control_register_wdata[POWER_CONTROL_REGISTER_PD_BIT]) begin
                    pwr_next = PWR_DOWN;
                end else if (power_control_register_wr_ok && i_power_control_register_wdata[POWER_CONTROL_REGISTER_IDLE_BIT]) begin
                    pwr_next = PWR_IDLE;
                end
            end
            PWR_IDLE: begin
                if (wake) begin
                    pwr_next = PWR_RUN;
                end
            end
            PWR_DOWN: begin
                pwr_next = PWR_DOWN;
            end
            default: begin
                pwr_next = PWR_RUN;
            end
        endcase
    end

    // Reset is synchronous and returns every mode to run, as at power-on.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pwr_reg <= PWR_RUN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_power_control_register <= POWER_CONTROL_REGISTER_RESET;
        end else if (power_control_register_wr_ok) begin
            o_power_control_register <= i_power_control_register_wdata;
        end else if (pwr_reg == PWR_IDLE && wake) begin
            o_power_control_register[POWER_CONTROL_REGISTER_IDLE_BIT] <= 1'b0;
        end
    end

    // Entering a low-power mode mid erase/write aborts that operation.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_nvm_abort <= 1'b0;
        end else begin
            o_nvm_abort <= power_control_register_wr_ok && i_erase_write_busy_flag
                && (i_power_control_register_wdata[POWER_CONTROL_REGISTER_PD_BIT] || i_power_control_register_wdata[POWER_CONTROL_REGISTER_IDLE_BIT]);
        end
    end

    // Only the CPU is frozen in idle; timers, serial port and this
    // interrupt logic keep their clock. Power-down stops the oscillator and
    // guarantees nothing beyond RAM and the nonvolatile array.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_cpu_halt                   <= 1'b0;
            o_osc_stop                   <= 1'b0;
            o_pin_override               <= 1'b0;
            o_ale_level                  <= 1'b0;
            o_program_store_strobe_level <= 1'b0;
            o_port0_float                <= 1'b0;
            o_port2_address              <= 1'b0;
        end else begin
            o_cpu_halt                   <= pwr_next != PWR_RUN;
            o_osc_stop                   <= pwr_next == PWR_DOWN;
            o_pin_override               <= pwr_next != PWR_RUN;
            o_ale_level                  <= pwr_next == PWR_IDLE;
            o_program_store_strobe_level <= pwr_next == PWR_IDLE;
            o_port0_float                <= (pwr_next != PWR_RUN) && ext_mem_reg;
            o_port2_address              <= (pwr_next == PWR_IDLE) && ext_mem_reg;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    logic [MC_CNT_W-1:0] wait_mc_reg;
    logic                serve_ok;

    // Only a request that outranks the service level is owed a quick answer.
    assign serve_ok = !in_hi_reg
        && ((|(eligible & i_source_high_pri)) || (!in_lo_reg && (|eligible)));

    always_ff @(posedge i_clk) begin
        if (i_srst || o_irq_req || !serve_ok || pwr_reg == PWR_DOWN) begin
            wait_mc_reg <= '0;
        end else if (mc_tick && wait_mc_reg != '1) begin
            wait_mc_reg <= wait_mc_reg + 1'b1;
        end
    end

    sequence s_idle_woken;
        (pwr_reg == PWR_IDLE) && wake;
    endsequence

    sequence s_resumed;
        (pwr_reg == PWR_RUN) && !o_power_control_register[POWER_CONTROL_REGISTER_IDLE_BIT] ##1 !o_cpu_halt;
    endsequence

    a_idle_halts_cpu:
    assert property ((pwr_reg == PWR_IDLE) |-> o_cpu_halt && !o_osc_stop)
        else $error("idle does not halt only the CPU");

    a_idle_wake_resume:
    assert property (s_idle_woken |=> s_resumed)
        else $error("enabled interrupt did not end idle");

    a_idle_bit_cleared:
    assert property (s_idle_woken |=> !o_power_control_register[POWER_CONTROL_REGISTER_IDLE_BIT])
        else $error("idle bit kept after wake");

    a_reset_to_run:
    assert property (@(posedge i_clk) disable iff (1'b0)
        i_srst |=> pwr_reg == PWR_RUN && !o_cpu_halt)
        else $error("reset did not restart");

    a_pd_stops_osc:
    assert property ($rose(pwr_reg == PWR_DOWN) |-> o_osc_stop && o_cpu_halt)
        else $error("oscillator not stopped in power-down");

    a_pd_no_wake:
    assert property ((pwr_reg == PWR_DOWN) |=> (pwr_reg == PWR_DOWN) && !o_irq_req)
        else $error("power-down left without reset");

    a_global_block:
    assert property (!i_global_enable |=> !o_irq_req)
        else $error("request despite global disable");

    a_nvm_gated:
    assert property (!i_source_enable[SRC_SERIAL] && o_irq_req |-> req_src_reg != SRC_SERIAL)
        else $error("shared vector without serial enable");

    a_nest_levels:
    assert property (o_irq_req |-> !in_hi_reg && (o_irq_high || !in_lo_reg))
        else $error("request does not outrank service level");

    a_vector_fixed:
    assert property (o_irq_req |-> o_irq_vector == VEC_EXT0 + VEC_W'({req_src_reg, 3'h0}))
        else $error("vector does not match source");

    a_latency_bound:
    assert property (wait_mc_reg < MC_CNT_W'(LAT_MIN_MC))
        else $error("request polled too late");

    a_idle_pins:
    assert property ((pwr_reg == PWR_IDLE) |-> o_ale_level && o_program_store_strobe_level
        && (o_port2_address == ext_mem_reg) && (o_port0_float == ext_mem_reg))
        else $error("idle pin state wrong");

    a_pd_pins:
    assert property ((pwr_reg == PWR_DOWN) |-> !o_ale_level && !o_program_store_strobe_level
        && !o_port2_address && (o_port0_float == ext_mem_reg))
        else $error("power-down pin state wrong");

endmodule

`default_nettype wire

// [verification/cpu_model.sv]
// CPU core model: acknowledges each request and returns after a fixed service time.
// Assumes the controller holds its request until the acknowledge is taken.
`default_nettype none

module cpu_model #(
    parameter int SVC = 60
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Interrupt handshake
    input  wire logic i_req,
    output logic      o_ack,
    output logic      o_reti
);
    timeunit 1ns;
    timeprecision 1ns;
    int depth;
    int cnt;
    initial begin
        o_ack = 1'b0;
        o_reti = 1'b0;
        depth = 0;
        cnt = 0;
    end
    // Returns are popped one per service time, so nested entries leave innermost first.
    always @(posedge i_clk) begin
        o_reti <= 1'b0;
        o_ack <= i_req && !o_ack && !i_srst;
        if (i_srst) begin
            depth = 0;
        end else if (o_ack) begin
            depth++;
            cnt = SVC;
        end else if (depth > 0) begin
            if (cnt == 0) begin
                o_reti <= 1'b1;
                depth--;
                cnt = SVC;
            end else begin
                cnt--;
            end
        end
    end
endmodule

`default_nettype wire

// [verification/tb_irq_power_ctrl.sv]
// Self-checking bench for the interrupt and power-mode controller.
// Assumes a CPU model that acknowledges each request and returns after a fixed time.
`default_nettype none

module tb_irq_power_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_power_pkg::*;
    logic clk = 0, srst = 1, e0_n = 1, e1_n = 1, t0 = 0, t1 = 0, ser = 0, nf = 0, ne = 0;
    logic busy = 0, gen = 1, wr = 0, ea_n = 1, ab;
    logic [1:0] lvl = 2'h0;
    logic [4:0] sen = 5'h1f, spri = 5'h00;
    logic [7:0] wd = 8'h00, power_control_register;
    logic [15:0] vec;
    logic [4:0] flg;
    logic req, hi, ack, reti, halt, osc, abort, ovr, ale, pse, p0f, p2a;
    int err_total = 0, comparisons = 0, cyc = 0, n;
    typedef struct { int k; logic [15:0] v; } row_s;
    row_s rows [6] = '{'{0, VEC_EXT0}, '{1, VEC_TMR0}, '{2, VEC_EXT1}, '{3, VEC_TMR1},
                       '{4, VEC_SERIAL}, '{5, VEC_SERIAL}};
    irq_power_ctrl dut_u (.i_clk(clk), .i_srst(srst), .i_ext_irq_0_n(e0_n),
        .i_external_irq_1_n(e1_n), .i_ext_access_n(ea_n), .i_timer0_ovf(t0),
        .i_timer1_ovf(t1), .i_serial_flag(ser), .i_nvm_irq_flag(nf), .i_nvm_irq_enable(ne),
        .i_erase_write_busy_flag(busy), .i_global_enable(gen), .i_source_enable(sen),
        .i_source_high_pri(spri), .i_ext_level_mode(lvl), .i_power_control_register_wr(wr),
        .i_power_control_register_wdata(wd), .o_power_control_register(power_control_register), .i_irq_ack(ack),
        .i_reti(reti), .o_irq_req(req), .o_irq_vector(vec), .o_irq_high(hi),
        .o_irq_flags(flg), .o_cpu_halt(halt), .o_osc_stop(osc), .o_nvm_abort(abort),
        .o_pin_override(ovr), .o_ale_level(ale), .o_program_store_strobe_level(pse),
        .o_port0_float(p0f), .o_port2_address(p2a));
    cpu_model cpu_u (.i_clk(clk), .i_srst(srst), .i_req(req), .o_ack(ack), .o_reti(reti));
    always #50 clk = ~clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(int c);
        repeat (c) @(posedge clk);
        #10;
    endtask
    task automatic chk(logic [16:0] got, logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic raise(int k, logic v);
        case (k)
            0: e0_n = !v;
            1: t0 = v;
            2: e1_n = !v;
            3: t1 = v;
            4: ser = v;
            default: begin nf = v; ne = v; end
        endcase
    endtask
    // Waits a bounded time for the request, or for the acknowledge when a is set.
    task automatic wait_for(logic a);
        n = 0;
        while ((a ? ack : req) !== 1'b1 && n < 40) begin tick(1); n++; end
        chk(a ? ack : req, 1);
    endtask
    task automatic pwr(logic [7:0] d);
        @(posedge clk); #10; wr = 1; wd = d;
        @(posedge clk); #10; wr = 0; ab = abort;
    endtask
    task automatic end_sim;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin err_total++; end_sim(); end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        tick(3); srst = 0; tick(1);
        chk({power_control_register, req, halt, osc, ovr}, 0);
        foreach (rows[i]) begin
            raise(rows[i].k, 1);
            wait_for(0); chk(vec, rows[i].v);
            wait_for(1); tick(2);
            chk(flg[rows[i].k > 4 ? 4 : rows[i].k], rows[i].k >= 4);
            raise(rows[i].k, 0); tick(70);
        end
        lvl = 2'h1; raise(0, 1); wait_for(0); wait_for(1); tick(2);
        chk(flg[0], 1);
        raise(0, 0); tick(4); chk(flg[0], 0); lvl = 2'h0; tick(70);
        gen = 0; raise(1, 1); tick(40); chk(req, 0);
        gen = 1; wait_for(0); chk(vec, VEC_TMR0); wait_for(1); raise(1, 0); tick(70);
        sen = 5'h0f; raise(5, 1); tick(40); chk(req, 0);
        raise(5, 0); sen = 5'h1f; tick(2);
        spri = 5'h08; raise(1, 1); wait_for(0); wait_for(1); raise(1, 0); tick(1);
        raise(3, 1); wait_for(0); chk({vec, hi}, {VEC_TMR1, 1'b1});
        wait_for(1); raise(3, 0); tick(150); spri = 5'h00;
        pwr(8'h01); chk({power_control_register, halt, ale, pse, ovr, p0f}, {8'h01, 5'b11110});
        raise(1, 1); wait_for(0); chk({power_control_register, halt}, 0);
        wait_for(1); raise(1, 0); tick(70);
        pwr(8'h02); chk({osc, halt, ale, pse, ovr}, 5'b11001);
        raise(1, 1); tick(40); chk({req, osc}, 2'b01); raise(1, 0);
        srst = 1; tick(3); srst = 0; tick(1); chk({power_control_register, osc, halt}, 0);
        pwr(8'h01); srst = 1; tick(3); srst = 0; tick(1); chk({power_control_register, halt}, 0);
        ea_n = 0; srst = 1; tick(3); srst = 0; tick(1);
        pwr(8'h01); chk({p0f, p2a, pse}, 3'h7);
        srst = 1; tick(3); srst = 0; tick(1);
        pwr(8'h02); chk({p0f, p2a, pse}, 3'h4);
        ea_n = 1; srst = 1; tick(3); srst = 0; tick(1);
        busy = 1; pwr(8'h01); chk(ab, 1);
        end_sim();
    end
endmodule

`default_nettype wire
